// ==== src/llsc_lock_ctl.v ====
/*
  Lock control for load-locked / store-conditional pairs, with APB access to
  the memory control register and a status register.
  Assumes the data cache, issue queue, fetch unit and system port logic sit
  on pclk and present one-cycle event pulses and lookup results.
*/
// The address map and the APB slave port were left to the implementer.
// How it works
// R1 - LL miss fetches block, fills clean
// R2 - SC succeeds only if resident and writable
// R3 - Lock is line residency, no lock register
// R4 - System must probe-invalidate before modifying
// R5 - SC port commands only when nonspeculative
// R6 - On success, SC data always written
// R7 - SC enters queue with store-wait bit set
// R8 - Conflicting istream reference made noncached
// R9 - SC interrupting a pair fails in order
// R10 - Older evicting ref replays, aborts LL
// R11 - Stall map stage until queue empty; here the stall also ends when the SC executes
// R12 - LL fetch flag forces not-taken predictions
// R13 - SC dcache miss fails, no port traffic
// R14 - Make-writable after retire, older stores writable
// R15 - Line locked against probes until written
// R16 - Conservative mode blocks speculative-store MISS_ADDRESS_FILE allocation
// R17 - Primary 8-bit counter, backup 16K/2M window
// R18 - Periodic mode enables both counters
// R19 - Clearing field resets backup counter
// R20 - Fail or fill response fails SC
// R21 - Conflicting istream fetched noncached, not installed
// R22 - Field encodes off, full-time, periodic
`include "llsc_consts.vh"

module llsc_lock_ctl #(
  parameter BK_PERIOD = `LLSC_BK_PERIOD,
  parameter BK_WINDOW = `LLSC_BK_WINDOW
) (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire ll_exec,
  input wire ll_dc_hit,
  input wire [`LLSC_IDX_W-1:0] ll_index,
  output reg read_block_cmd,
  output reg [`LLSC_IDX_W-1:0] read_block_index,
  input wire fill_resp,
  output reg fill_clean,
  input wire ll_probe_inval,
  input wire sc_enq,
  output wire store_wait_bit,
  input wire older_ll_in_iq,
  output wire sc_may_issue,
  input wire iq_empty,
  output wire map_stall,
  input wire sc_exec,
  input wire sc_dc_hit,
  input wire sc_dc_dirty,
  input wire sc_dc_shared,
  input wire sc_pair_broken,
  input wire sc_retired,
  input wire sc_nonspec,
  input wire older_stq_writable,
  output reg make_writable_cmd,
  output reg make_writable_shared,
  input wire make_writable_success_resp,
  input wire make_writable_fail_resp,
  output reg sc_dc_write,
  input wire sc_dc_write_done,
  output reg sc_done,
  output reg sc_success,
  output wire probe_hold,
  input wire older_ref_hits_ll,
  output reg replay_trap,
  output reg ll_abort,
  input wire is_ref_valid,
  input wire is_bc_index_match,
  input wire is_bc_tag_match,
  output reg is_noncached,
  output reg is_bc_install,
  input wire fetch_ll_ref,
  input wire fetch_other_ref,
  output wire predict_not_taken,
  input wire br_mispredict,
  input wire cond_br_retire,
  input wire spec_store_maf_req,
  output wire maf_alloc_block
);

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  reg [1:0] smc_q;
  reg ll_active_q;
  reg line_lock_q;
  reg fetch_flag_q;
  reg [2:0] sc_state_q;
  reg [`LLSC_PRIM_W-1:0] prim_q;
  wire cons_active;
  wire [`LLSC_ADDR_W-1:0] reg_addr;
  wire apb_acc;
  wire hit_mctl;
  wire hit_stat;
  wire smc_cleared;

  assign reg_addr = paddr[`LLSC_ADDR_W-1:0];
  assign hit_mctl = (paddr[31:`LLSC_ADDR_W] == 20'h00000) & (reg_addr == `LLSC_ADDR_MCTL);
  assign hit_stat = (paddr[31:`LLSC_ADDR_W] == 20'h00000) & (reg_addr == `LLSC_ADDR_STAT);
  assign apb_acc = psel & penable & ce;
  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_mctl & ~hit_stat;
  // Status is read-only; writing it answers without error but stores nothing
  assign smc_cleared = apb_acc & pwrite & hit_mctl & (smc_q != `LLSC_SMC_OFF) &
                       (pwdata[`LLSC_SMC_MSB:`LLSC_SMC_LSB] == `LLSC_SMC_OFF);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smc_q <= `LLSC_MCTL_RST;
    end else if (apb_acc && pwrite && hit_mctl) begin
      smc_q <= pwdata[`LLSC_SMC_MSB:`LLSC_SMC_LSB]; // R22
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (ce && psel && !penable && !pwrite) begin
      prdata <= 32'h00000000;
      if (hit_mctl) begin
        prdata[`LLSC_SMC_MSB:`LLSC_SMC_LSB] <= smc_q;
      end else if (hit_stat) begin
        prdata[`LLSC_ST_LL_ACTIVE] <= ll_active_q;
        prdata[`LLSC_ST_LINE_LOCK] <= line_lock_q;
        prdata[`LLSC_ST_FETCH_FLAG] <= fetch_flag_q;
        prdata[`LLSC_ST_CONS] <= cons_active;
        prdata[`LLSC_ST_SC_MSB:`LLSC_ST_SC_LSB] <= sc_state_q;
        prdata[`LLSC_ST_PRIM_MSB:`LLSC_ST_PRIM_LSB] <= prim_q;
      end
    end
  end

  // ------------------------------------------------------------
  // Load-locked path
  // ------------------------------------------------------------
  reg ll_pend_q;
  wire sc_finish;

  // Residency of the filled line is the lock; only an armed flag is kept
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ll_pend_q <= 1'b0;
      read_block_cmd <= 1'b0;
      read_block_index <= {`LLSC_IDX_W{1'b0}};
      fill_clean <= 1'b0;
    end else if (ce) begin
      read_block_cmd <= 1'b0;
      fill_clean <= 1'b0;
      if (ll_exec && !ll_dc_hit) begin
        ll_pend_q <= 1'b1;
        read_block_cmd <= 1'b1; // R1
        read_block_index <= ll_index;
      end else if (ll_pend_q && fill_resp) begin
        ll_pend_q <= 1'b0;
        fill_clean <= 1'b1; // R1
      end
    end
  end

  // Arm wins over any clear landing in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ll_active_q <= 1'b0;
    end else if (ce) begin
      if ((ll_exec && ll_dc_hit) || (ll_pend_q && fill_resp)) begin
        ll_active_q <= 1'b1; // R3
      end else if (ll_probe_inval && !line_lock_q) begin
        ll_active_q <= 1'b0; // R4
      end else if (older_ref_hits_ll || sc_finish) begin
        ll_active_q <= 1'b0;
      end
    end
  end

  // Older reference about to evict the locked line
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      replay_trap <= 1'b0;
      ll_abort <= 1'b0;
    end else if (ce) begin
      replay_trap <= older_ref_hits_ll & ll_active_q; // R10
      ll_abort <= older_ref_hits_ll & ll_active_q; // R10
    end
  end

  // ------------------------------------------------------------
  // Issue queue ordering
  // ------------------------------------------------------------
  reg sc_in_iq_q;

  assign store_wait_bit = sc_enq; // R7
  assign sc_may_issue = sc_in_iq_q & ~older_ll_in_iq; // R7
  // Stall holds newer loads and stores out until the SC executes or the queue drains
  assign map_stall = (sc_in_iq_q | sc_enq) & ~iq_empty; // R11

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_in_iq_q <= 1'b0;
    end else if (ce) begin
      if (sc_enq) begin
        sc_in_iq_q <= 1'b1;
      end else if (sc_exec || iq_empty) begin
        sc_in_iq_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Fetch-side flag
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_flag_q <= 1'b0;
    end else if (ce) begin
      if (fetch_ll_ref) begin
        fetch_flag_q <= 1'b1; // R12
      end else if (fetch_other_ref) begin
        fetch_flag_q <= 1'b0; // R12
      end
    end
  end

  assign predict_not_taken = fetch_flag_q; // R12

  // ------------------------------------------------------------
  // Instruction-stream conflict
  // ------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      is_noncached <= 1'b0;
      is_bc_install <= 1'b0;
    end else if (ce) begin
      is_noncached <= is_ref_valid & is_bc_index_match & ~is_bc_tag_match; // R8 R21
      is_bc_install <= is_ref_valid & ~(is_bc_index_match & ~is_bc_tag_match); // R21
    end
  end

  // ------------------------------------------------------------
  // Store-conditional sequence
  // ------------------------------------------------------------
  reg [2:0] sc_state_d;
  reg sc_fail_now;
  wire sc_launch;

  // Port commands wait for retirement and nonspeculative status, so none are ever speculative
  assign sc_launch = sc_retired & sc_nonspec & older_stq_writable; // R5 R14
  assign sc_finish = (sc_state_q == `LLSC_SC_WRITE) & sc_dc_write_done;
  // Probes stall while the line is locked for the store data
  assign probe_hold = line_lock_q; // R15

  always @* begin
    sc_state_d = sc_state_q;
    sc_fail_now = 1'b0;
    case (sc_state_q)
      `LLSC_SC_IDLE: begin
        if (sc_exec) begin
          if (!sc_dc_hit || sc_pair_broken || !ll_active_q) begin
            sc_fail_now = 1'b1; // R2 R9 R13
          end else if (sc_dc_dirty) begin
            sc_state_d = `LLSC_SC_WRITE; // R2
          end else begin
            sc_state_d = `LLSC_SC_RETIRE;
          end
        end
      end
      `LLSC_SC_RETIRE: begin
        if (!ll_active_q) begin
          sc_fail_now = 1'b1; // R2
          sc_state_d = `LLSC_SC_IDLE;
        end else if (sc_launch) begin
          sc_state_d = `LLSC_SC_RESP; // R14
        end
      end
      `LLSC_SC_RESP: begin
        if (make_writable_success_resp) begin
          sc_state_d = `LLSC_SC_WRITE; // R20
        end else if (make_writable_fail_resp || fill_resp) begin
          sc_fail_now = 1'b1; // R20
          sc_state_d = `LLSC_SC_IDLE;
        end
      end
      `LLSC_SC_WRITE: begin
        if (sc_dc_write_done) begin
          sc_state_d = `LLSC_SC_IDLE;
        end
      end
      default: begin
        sc_state_d = `LLSC_SC_IDLE;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_state_q <= `LLSC_SC_IDLE;
      make_writable_cmd <= 1'b0;
      make_writable_shared <= 1'b0;
      sc_dc_write <= 1'b0;
      sc_done <= 1'b0;
      sc_success <= 1'b0;
      line_lock_q <= 1'b0;
    end else if (ce) begin
      sc_state_q <= sc_state_d;
      make_writable_cmd <= 1'b0;
      sc_done <= 1'b0;
      if ((sc_state_q == `LLSC_SC_RETIRE) && ll_active_q && sc_launch) begin
        make_writable_cmd <= 1'b1; // R14
        make_writable_shared <= sc_dc_shared;
      end
      if ((sc_state_q == `LLSC_SC_RESP) && make_writable_success_resp) begin
        line_lock_q <= 1'b1; // R15
      end else if (sc_finish) begin
        line_lock_q <= 1'b0; // R15
      end
      // Once committed the write is held until the cache takes it
      sc_dc_write <= (sc_state_d == `LLSC_SC_WRITE); // R6
      if (sc_fail_now) begin
        sc_done <= 1'b1;
        sc_success <= 1'b0; // R9
      end else if (sc_finish) begin
        sc_done <= 1'b1;
        sc_success <= 1'b1; // R6
      end
    end
  end

  // ------------------------------------------------------------
  // Conservative mode
  // ------------------------------------------------------------
  localparam [`LLSC_BK_W-1:0] BK_LAST = BK_PERIOD - 1;
  localparam [`LLSC_BK_W-1:0] BK_WIN = BK_WINDOW;
  localparam [`LLSC_PRIM_WIN_W-1:0] PRIM_LAST = `LLSC_PRIM_WIN - 1;
  wire periodic;
  wire prim_tc;
  wire [`LLSC_BK_W-1:0] bk_cnt;
  wire [`LLSC_PRIM_WIN_W-1:0] pwin_cnt;
  wire pwin_wrap;
  reg pwin_q;

  assign periodic = (smc_q == `LLSC_SMC_PERIODIC); // R18
  assign prim_tc = periodic & (br_mispredict | cond_br_retire) & (prim_q == `LLSC_PRIM_TC); // R22

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prim_q <= {`LLSC_PRIM_W{1'b0}};
      pwin_q <= 1'b0;
    end else if (ce) begin
      if (!periodic) begin
        prim_q <= {`LLSC_PRIM_W{1'b0}};
        pwin_q <= 1'b0;
      end else begin
        if (br_mispredict || cond_br_retire) begin
          prim_q <= prim_q + 8'h01; // R17
        end
        if (prim_tc) begin
          pwin_q <= 1'b1; // R22
        end else if (pwin_wrap) begin
          pwin_q <= 1'b0;
        end
      end
    end
  end

  llsc_cycle_ctr #(
    .W(`LLSC_PRIM_WIN_W),
    .LAST(PRIM_LAST)
  ) u_prim_win (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .en(pwin_q),
    .clr(prim_tc),
    .cnt_q(pwin_cnt),
    .wrap(pwin_wrap)
  );

  // Backup window opens at count zero of each period
  llsc_cycle_ctr #(
    .W(`LLSC_BK_W),
    .LAST(BK_LAST)
  ) u_backup (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .en(periodic), // R18
    .clr(smc_cleared), // R19
    .cnt_q(bk_cnt),
    .wrap()
  );

  assign cons_active = (smc_q == `LLSC_SMC_FULL) |
                       (periodic & (pwin_q | (bk_cnt < BK_WIN))); // R17
  assign maf_alloc_block = cons_active & spec_store_maf_req; // R16

endmodule

// ==== src/llsc_consts.vh ====
/*
  Constants for the load-locked / store-conditional lock control block:
  register offsets, field layout, reset values, state codes and cycle counts.
  Assumes inclusion by bare name from files under src/.
*/
`ifndef LLSC_CONSTS_VH
`define LLSC_CONSTS_VH

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define LLSC_ADDR_MCTL 12'h000
`define LLSC_ADDR_STAT 12'h004
`define LLSC_ADDR_W 12

// ------------------------------------------------------------
// Memory control register fields
// ------------------------------------------------------------
`define LLSC_SMC_LSB 0
`define LLSC_SMC_MSB 1
`define LLSC_SMC_OFF 2'h0
`define LLSC_SMC_FULL 2'h1
`define LLSC_SMC_PERIODIC 2'h2
`define LLSC_MCTL_RST 2'h0

// ------------------------------------------------------------
// Status register fields
// ------------------------------------------------------------
`define LLSC_ST_LL_ACTIVE 0
`define LLSC_ST_LINE_LOCK 1
`define LLSC_ST_FETCH_FLAG 2
`define LLSC_ST_CONS 3
`define LLSC_ST_SC_LSB 4
`define LLSC_ST_SC_MSB 6
`define LLSC_ST_PRIM_LSB 8
`define LLSC_ST_PRIM_MSB 15

// ------------------------------------------------------------
// Store-conditional states
// ------------------------------------------------------------
`define LLSC_SC_IDLE 3'h0
`define LLSC_SC_RETIRE 3'h1
`define LLSC_SC_RESP 3'h2
`define LLSC_SC_WRITE 3'h3

// ------------------------------------------------------------
// Widths and cycle counts
// ------------------------------------------------------------
`define LLSC_IDX_W 10
`define LLSC_PRIM_W 8
`define LLSC_PRIM_TC 8'hFF
`define LLSC_PRIM_WIN 256
`define LLSC_PRIM_WIN_W 9
`define LLSC_BK_PERIOD 2000000
`define LLSC_BK_WINDOW 16384
`define LLSC_BK_W 21

`endif

// ==== src/llsc_cycle_ctr.v ====
/*
  Cycle counter that counts only while enabled, with clear and wrap pulse, used for conservative windows.
  Assumes one clock, asynchronous active-low reset and a shared clock enable.
*/
module llsc_cycle_ctr #(
  parameter W = 8,
  parameter [W-1:0] LAST = {W{1'b1}}
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire en,
  input wire clr,
  output reg [W-1:0] cnt_q,
  output wire wrap
);

  assign wrap = en & (cnt_q == LAST);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= {W{1'b0}};
    end else if (ce) begin
      if (clr || !en) begin
        cnt_q <= {W{1'b0}};
      end else if (wrap) begin
        cnt_q <= {W{1'b0}};
      end else begin
        cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// ==== bench/llsc_lock_chk.sv ====
/*
  Lock control checker, bound to its ports.
  Assumes one clock, active-low async reset and ce held high.
*/
module llsc_lock_chk (
  input pclk,
  input presetn,
  input ce,
  input ll_exec,
  input ll_dc_hit,
  input read_block_cmd,
  input fill_resp,
  input fill_clean,
  input sc_enq,
  input store_wait_bit,
  input older_ll_in_iq,
  input sc_may_issue,
  input iq_empty,
  input map_stall,
  input sc_exec,
  input sc_dc_hit,
  input sc_retired,
  input sc_nonspec,
  input older_stq_writable,
  input make_writable_cmd,
  input make_writable_success_resp,
  input make_writable_fail_resp,
  input sc_dc_write,
  input sc_dc_write_done,
  input sc_done,
  input sc_success,
  input probe_hold,
  input replay_trap,
  input ll_abort,
  input is_ref_valid,
  input is_bc_index_match,
  input is_bc_tag_match,
  input is_noncached,
  input is_bc_install,
  input fetch_ll_ref,
  input predict_not_taken
);
  logic busy_q, wait_q;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);

  // ----------------------------------------
  // SC tracking
  // ----------------------------------------
  // A busy SC ignores sc_exec
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'h0;
      wait_q <= 1'h0;
    end else begin
      busy_q <= sc_done ? 1'h0 : (sc_exec | busy_q);
      wait_q <= make_writable_cmd | (wait_q & ~make_writable_success_resp & ~make_writable_fail_resp & ~fill_resp);
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  AST_RB_MISS: assert property (ll_exec && !ll_dc_hit |=> read_block_cmd)
    else $error("no read block");
  AST_FILL: assert property (fill_clean |-> $past(fill_resp))
    else $error("stray fill");
  AST_CMD_GATE: assert property (make_writable_cmd |-> $past(sc_retired && sc_nonspec && older_stq_writable))
    else $error("early command");
  AST_SC_MISS: assert property (sc_exec && !busy_q && !sc_dc_hit |=> sc_done && !sc_success && !make_writable_cmd)
    else $error("miss not failed");
  AST_RESP_FAIL: assert property (wait_q && (make_writable_fail_resp || fill_resp) |=> sc_done && !sc_success)
    else $error("response not failed");
  AST_LOCK: assert property (wait_q && make_writable_success_resp |=> probe_hold && sc_dc_write)
    else $error("no lock");
  AST_WR_HOLD: assert property (sc_dc_write && !sc_dc_write_done |=> sc_dc_write)
    else $error("write dropped");
  AST_LOCK_HOLD: assert property (probe_hold && !sc_dc_write_done |=> probe_hold)
    else $error("lock dropped");
  AST_DONE: assert property (sc_dc_write && sc_dc_write_done |=> sc_done && sc_success && !probe_hold)
    else $error("write not done");
  AST_STORE_WAIT_BIT: assert property (sc_enq |-> store_wait_bit)
    else $error("no wait bit");
  AST_NO_ISSUE: assert property (older_ll_in_iq |-> !sc_may_issue)
    else $error("early issue");
  AST_MAP: assert property (sc_enq && !iq_empty |-> map_stall)
    else $error("no stall");
  AST_PRED: assert property (fetch_ll_ref |=> predict_not_taken)
    else $error("no flag");
  AST_NC: assert property (is_ref_valid && is_bc_index_match && !is_bc_tag_match |=> is_noncached && !is_bc_install)
    else $error("not noncached");
  AST_REPLAY: assert property (replay_trap |-> ll_abort)
    else $error("no abort");
endmodule

// ==== bench/llsc_sys_model.sv ====
/*
  System controller model: answers read-block and make-writable commands.
  Assumes one outstanding command of each kind; delay and answer set by bench.
*/
module llsc_sys_model (
  input logic pclk,
  input logic presetn,
  input logic read_block_cmd,
  input logic make_writable_cmd,
  input logic [1:0] mode,
  input logic [3:0] dly,
  input logic probe_req,
  output logic fill_resp,
  output logic make_writable_success_resp,
  output logic make_writable_fail_resp,
  output logic ll_probe_inval
);
  timeunit 1ns;
  timeprecision 1ps;
  int rb_q, mw_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rb_q <= 0;
      mw_q <= 0;
      fill_resp <= 1'h0;
      make_writable_success_resp <= 1'h0;
      make_writable_fail_resp <= 1'h0;
      ll_probe_inval <= 1'h0;
    end else begin
      ll_probe_inval <= probe_req;
      fill_resp <= (rb_q == 1) || (mw_q == 1 && mode == 2'h2);
      make_writable_success_resp <= mw_q == 1 && mode == 2'h0;
      make_writable_fail_resp <= mw_q == 1 && mode == 2'h1;
      rb_q <= read_block_cmd ? dly + 1 : (rb_q > 0 ? rb_q - 1 : 0);
      mw_q <= make_writable_cmd ? dly + 1 : (mw_q > 0 ? mw_q - 1 : 0);
    end
  end
endmodule

// ==== bench/load_lock_store_conditional_tb_top.sv ====
/*
  Top testbench for the lock control block with the system model.
  Assumes 125 MHz; backup window 8 of 64 cycles.
*/
module load_lock_store_conditional_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'h0, presetn = 1'h0, ce = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic [9:0] ll_index = 10'h0, read_block_index;
  logic ll_exec = 1'h0, ll_dc_hit = 1'h0, sc_enq = 1'h0, older_ll_in_iq = 1'h0, iq_empty = 1'h1;
  logic sc_exec = 1'h0, sc_dc_hit = 1'h0, sc_dc_dirty = 1'h0, sc_dc_shared = 1'h0, sc_pair_broken = 1'h0;
  logic sc_retired = 1'h0, sc_nonspec = 1'h0, older_stq_writable = 1'h0, sc_dc_write_done = 1'h0;
  logic older_ref_hits_ll = 1'h0, is_ref_valid = 1'h0, is_bc_index_match = 1'h0, is_bc_tag_match = 1'h0;
  logic fetch_ll_ref = 1'h0, fetch_other_ref = 1'h0, br_mispredict = 1'h0, cond_br_retire = 1'h0;
  logic spec_store_maf_req = 1'h0, probe_req = 1'h0;
  logic [1:0] mode = 2'h0;
  logic [3:0] dly = 4'h3;
  logic pready, pslverr, read_block_cmd, fill_resp, fill_clean, ll_probe_inval, store_wait_bit;
  logic sc_may_issue, map_stall, make_writable_cmd, make_writable_shared, make_writable_success_resp;
  logic make_writable_fail_resp, sc_dc_write, sc_done, sc_success, probe_hold, replay_trap, ll_abort;
  logic is_noncached, is_bc_install, predict_not_taken, maf_alloc_block;
  int mismatches = 0, n_compared = 0, n_cmd = 0, cycles = 0;

  llsc_lock_ctl #(.BK_PERIOD(64), .BK_WINDOW(8)) u_dut (.*);
  llsc_sys_model u_sys (.*);

  always #4 pclk = ~pclk;

  // ----------------------------------------
  // Monitors
  // ----------------------------------------
  // Whole run needs about 190 cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (make_writable_cmd === 1'h1) n_cmd <= n_cmd + 1;
    if (cycles == 5000) begin
      mismatches++;
      results();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] s, e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task apb(input logic w, input logic [31:0] a, d, output logic [31:0] r, output logic err);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task wr(input logic [31:0] a, d);
    logic [31:0] r;
    logic e;
    apb(1'h1, a, d, r, e);
  endtask

  task rdc(input logic [31:0] a, x, output logic [31:0] r);
    logic e;
    apb(1'h0, a, 32'h0, r, e);
    chk("read_err", e, 32'h0);
    chk("read_data", r, x);
  endtask

  task ll_go(input logic h);
    @(posedge pclk);
    ll_exec <= 1'h1;
    ll_dc_hit <= h;
    ll_index <= 10'h2A5;
    @(posedge pclk);
    ll_exec <= 1'h0;
  endtask

  task sc_go(input logic h, input logic s, input logic b);
    @(posedge pclk);
    sc_exec <= 1'h1;
    sc_dc_hit <= h;
    sc_dc_shared <= s;
    sc_pair_broken <= b;
    @(posedge pclk);
    sc_exec <= 1'h0;
  endtask

  task probe;
    @(posedge pclk);
    probe_req <= 1'h1;
    @(posedge pclk);
    probe_req <= 1'h0;
    repeat (2) @(posedge pclk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    logic [31:0] r;
    logic e;
    rdc(32'h0, 32'h0, r);
    rdc(32'h4, 32'h0, r);
    for (int m = 0; m < 3; m++) begin
      wr(32'h0, 32'(m));
      rdc(32'h0, 32'(m), r);
    end
    wr(32'h0, 32'h0);
    wr(32'h4, 32'hFFFFFFFF);
    rdc(32'h4, 32'h0, r);
    apb(1'h0, 32'h8, 32'h0, r, e);
    chk("unmap_err", e, 32'h1);
  endtask

  task t_queue;
    @(posedge pclk);
    sc_enq <= 1'h1;
    older_ll_in_iq <= 1'h1;
    iq_empty <= 1'h0;
    @(negedge pclk);
    chk("wait_bit", store_wait_bit, 32'h1);
    chk("stall", map_stall, 32'h1);
    @(posedge pclk);
    sc_enq <= 1'h0;
    @(negedge pclk);
    chk("may_issue", sc_may_issue, 32'h0);
    @(posedge pclk);
    older_ll_in_iq <= 1'h0;
    @(negedge pclk);
    chk("may_issue", sc_may_issue, 32'h1);
    chk("stall", map_stall, 32'h1);
    @(posedge pclk);
    iq_empty <= 1'h1;
    @(negedge pclk);
    chk("stall", map_stall, 32'h0);
  endtask

  task t_front;
    @(posedge pclk);
    is_ref_valid <= 1'h1;
    is_bc_index_match <= 1'h1;
    fetch_ll_ref <= 1'h1;
    @(posedge pclk);
    is_ref_valid <= 1'h0;
    fetch_ll_ref <= 1'h0;
    @(negedge pclk);
    chk("noncached", is_noncached, 32'h1);
    chk("install", is_bc_install, 32'h0);
    chk("not_taken", predict_not_taken, 32'h1);
    @(posedge pclk);
    fetch_other_ref <= 1'h1;
    @(negedge pclk);
    @(posedge pclk);
    fetch_other_ref <= 1'h0;
    @(negedge pclk);
    chk("not_taken", predict_not_taken, 32'h0);
  endtask

  task t_replay;
    logic [31:0] r;
    ll_go(1'h1);
    @(posedge pclk);
    older_ref_hits_ll <= 1'h1;
    @(posedge pclk);
    older_ref_hits_ll <= 1'h0;
    @(negedge pclk);
    chk("replay", replay_trap, 32'h1);
    rdc(32'h4, 32'h0, r);
  endtask

  task t_sc_quick;
    for (int k = 0; k < 3; k++) begin
      ll_go(1'h1);
      if (k == 2) probe();
      sc_go(k != 0, 1'h0, k == 1);
      @(negedge pclk);
      chk("quick_done", sc_done, 32'h1);
      chk("quick_ok", sc_success, 32'h0);
    end
    chk("quick_cmds", n_cmd, 32'h0);
  endtask

  task t_sc_ok;
    logic [31:0] r;
    ll_go(1'h0);
    @(negedge pclk);
    chk("rb_cmd", read_block_cmd, 32'h1);
    chk("rb_index", read_block_index, 32'h2A5);
    wait (fill_clean === 1'h1);
    rdc(32'h4, 32'h1, r);
    sc_retired <= 1'h1;
    older_stq_writable <= 1'h1;
    sc_go(1'h1, 1'h0, 1'h0);
    repeat (4) @(posedge pclk);
    chk("spec_cmds", n_cmd, 32'h0);
    sc_nonspec <= 1'h1;
    wait (sc_dc_write === 1'h1);
    chk("cmds", n_cmd, 32'h1);
    probe();
    rdc(32'h4, 32'h33, r);
    sc_dc_write_done <= 1'h1;
    @(posedge pclk);
    sc_dc_write_done <= 1'h0;
    @(negedge pclk);
    chk("ok_done", sc_done, 32'h1);
    chk("ok_success", sc_success, 32'h1);
  endtask

  task t_sc_fail;
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk);
      mode <= 2'(i + 1);
      dly <= 4'h0;
      ll_go(1'h1);
      sc_go(1'h1, 1'(i), 1'h0);
      wait (sc_done === 1'h1);
      chk("variant", make_writable_shared, 32'(i));
      chk("resp_success", sc_success, 32'h0);
    end
  endtask

  task t_cons;
    logic [31:0] r;
    logic e;
    @(posedge pclk);
    spec_store_maf_req <= 1'h1;
    br_mispredict <= 1'h1;
    @(posedge pclk);
    br_mispredict <= 1'h0;
    @(negedge pclk);
    chk("maf_off", maf_alloc_block, 32'h0);
    wr(32'h0, 32'h1);
    @(negedge pclk);
    chk("maf_full", maf_alloc_block, 32'h1);
    wr(32'h0, 32'h2);
    repeat (2) @(negedge pclk);
    chk("maf_window", maf_alloc_block, 32'h1);
    repeat (20) @(negedge pclk);
    chk("maf_gap", maf_alloc_block, 32'h0);
    for (int j = 0; j < 5; j++) begin
      @(posedge pclk);
      br_mispredict <= j < 3;
      cond_br_retire <= j >= 3;
    end
    @(posedge pclk);
    br_mispredict <= 1'h0;
    cond_br_retire <= 1'h0;
    apb(1'h0, 32'h4, 32'h0, r, e);
    chk("stat_err", e, 32'h0);
    chk("armed", 32'(r[0]), 32'h1);
    chk("primary", 32'(r[15:8]), 32'h5);
    wr(32'h0, 32'h0);
    wr(32'h0, 32'h2);
    repeat (2) @(negedge pclk);
    chk("maf_resync", maf_alloc_block, 32'h1);
    wr(32'h0, 32'h0);
  endtask

  task results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    t_regs();
    t_queue();
    t_front();
    t_replay();
    t_sc_quick();
    t_sc_ok();
    t_sc_fail();
    t_cons();
    results();
  end
endmodule

bind llsc_lock_ctl llsc_lock_chk u_chk (.*);
